// >>> include/pmw_consts.svh
// Register map, field positions and widths of the power mode controller
// Assumes a 32-bit APB register bus with an 8-bit byte address
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH
// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PMW_A_CTRL     8'h00
`define PMW_A_STAT     8'h04
`define PMW_A_WEN      8'h08
`define PMW_A_WPEND    8'h0c
`define PMW_A_DIOEDGE  8'h10
`define PMW_A_CMPCFG   8'h14
`define PMW_A_TMR0LO   8'h20
`define PMW_A_TMR0HI   8'h24
`define PMW_A_TMR1LO   8'h28
`define PMW_A_TMR1HI   8'h2c
`define PMW_A_PCNT0    8'h30
`define PMW_A_PCNT1    8'h34
// ****************************************************************
// Control register fields
// ****************************************************************
`define PMW_C_SLEEP    0
`define PMW_C_DEEP     1
`define PMW_C_DOZE     2
`define PMW_C_RAMRET   3
`define PMW_C_OSCOFF   4
`define PMW_C_TMROFF   5
`define PMW_C_ANAON    6
`define PMW_C_DEB      7
`define PMW_CTRL_RST   9'h040
// ****************************************************************
// Wake sources and widths
// ****************************************************************
`define PMW_NDIO       8
`define PMW_NSRC       14
`define PMW_W_TMR      8
`define PMW_W_PCNT     10
`define PMW_W_CMP      12
`define PMW_TMR_W      35
`define PMW_TMR_HI_W   3
`define PMW_PCNT_W     16
`endif

// >>> include/pmw_pkg.sv
// Types shared by the power mode controller
// Assumes nothing of its surroundings
package pmw_pkg;
    typedef enum logic [2:0] {
        ST_ACTIVE   = 3'h0,
        ST_DOZE     = 3'h1,
        ST_SLEEP    = 3'h2,
        ST_DEEP     = 3'h3,
        ST_WAKE_BOD = 3'h4,
        ST_WAKE_OSC = 3'h5,
        ST_WAKE_PWR = 3'h6,
        ST_WAKE_RST = 3'h7
    } pmw_state_t;
endpackage

// >>> core/pmw_power_wakeup_ctrl.sv
// Power mode, domain switching and wake-up controller with APB registers
// Assumes one 250 MHz clock; pins and analogue levels arrive asynchronous
//
// Functional notes
// [RULE_01] Three modes: active, sleep, deep sleep, each a set of domains.
// [RULE_02] Always-on side stays up; timers and 32k oscillator switchable.
// [RULE_03] Digital domain is off in sleep.
// [RULE_04] Analogue domain off in sleep, software switched when active.
// [RULE_05] RAM powered in sleep only if retention chosen before entry.
// [RULE_06] Radio powered only on baseband request, never in sleep.
// [RULE_07] Doze halts CPU; any interrupt request ends it.
// [RULE_08] I/O pin state is held through sleep.
// [RULE_09] Both analogue outputs go high impedance on sleep entry.
// [RULE_10] Switched-off 32k oscillator restarts on any wake event.
// [RULE_11] Wake only from enabled pin, timer, counter or comparator events.
// [RULE_12] Pending wake at sleep request wakes at once; software clears.
// [RULE_13] Wake: brown-out check, 32M oscillator stable, power, then reset.
// [RULE_14] Two 35-bit timers on 32k ticks, wake, keep counting.
// [RULE_15] Each pin wakes on selectable edge, even in alternate use.
// [RULE_16] Comparators wake on selected edge; levels readable.
// [RULE_17] Software sets comparator negative input to pin before sleep.
// [RULE_18] Two 16-bit pulse counters wake and never stop counting.
// [RULE_19] Counters wake without 32k oscillator unless debounce selected.
// [RULE_20] Deep sleep: all off; pin event exit gives full chip reset.
// [RULE_21] Status shows wake-from-sleep reset and pending wake sources.
`timescale 1ns/1ns
`include "pmw_consts.svh"

module pmw_power_wakeup_ctrl (
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Pins and analogue levels
    input  wire logic                 externalResetPinN,
    input  wire logic [`PMW_NDIO-1:0] generalIoPin,
    input  wire logic [1:0]           pulsePin,
    input  wire logic [1:0]           cmpLevel,
    input  wire logic                 osc32Clk,
    input  wire logic                 bodOk,
    input  wire logic                 osc32mStable,
    // On-chip requests
    input  wire logic                 irqAny,
    input  wire logic                 radioReq,
    // Domain and sequencing controls
    output logic                      pwrDigital,
    output logic                      pwrAnalog,
    output logic                      pwrRam,
    output logic                      pwrRadio,
    output logic                      cpuHalt,
    output logic                      cpuReset,
    output logic                      chipReset,
    output logic                      ioHold,
    output logic                      dacHiZ,
    output logic                      osc32Enable,
    output logic                      osc32mEnable,
    output logic                      wakeTimersOn
);
    // ****************************************************************
    // Synchronisers: stage 1 feeds stage 2 only, stage 3 for edges
    // ****************************************************************
    localparam int NS = `PMW_NDIO + 8;
    logic [NS-1:0] syn1_reg, syn2_reg, syn3_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            syn1_reg <= '0;
            syn2_reg <= '0;
            syn3_reg <= '0;
        end else if (ce) begin
            syn1_reg <= {bodOk, osc32mStable, externalResetPinN, osc32Clk,
                         cmpLevel, pulsePin, generalIoPin};
            syn2_reg <= syn1_reg;
            syn3_reg <= syn2_reg;
        end
    end
    logic [`PMW_NDIO-1:0] dioNow, dioOld;
    logic [1:0] pulseNow, cmpNow, cmpOld;
    logic tick, pinRst, rstAll, bodOkS, oscStableS;
    assign dioNow     = syn2_reg[`PMW_NDIO-1:0];
    assign dioOld     = syn3_reg[`PMW_NDIO-1:0];
    assign pulseNow   = syn2_reg[`PMW_NDIO+1:`PMW_NDIO];
    assign cmpNow     = syn2_reg[`PMW_NDIO+3:`PMW_NDIO+2];
    assign cmpOld     = syn3_reg[`PMW_NDIO+3:`PMW_NDIO+2];
    assign tick       = syn2_reg[NS-4] & ~syn3_reg[NS-4] & osc32Enable;
    assign pinRst     = ~syn2_reg[NS-3];
    assign oscStableS = syn2_reg[NS-2];
    assign bodOkS     = syn2_reg[NS-1];
    // External pin acts as a reset; sync stages keep the pure reset
    assign rstAll     = rst | pinRst; // [RULE_20]

    // ****************************************************************
    // APB slave: one wait state, answer always from flops
    // ****************************************************************
    logic apbAcc, apbDone, wrDone, mapped;
    logic [31:0] rdNext;
    assign apbAcc  = psel & penable & ~pready;
    assign apbDone = psel & penable & pready;
    assign wrDone  = apbDone & pwrite & ~pslverr & ce;

    logic [8:0]           ctrl_reg;
    logic [`PMW_NSRC-1:0] wen_reg, pend_reg, ev;
    logic [`PMW_NDIO-1:0] dioEdge_reg;
    logic [1:0]           cmpEdge_reg;
    logic                 fromSleep_reg, fromDeep_reg;
    logic [`PMW_TMR_W-1:0]  tmrCnt_reg [2];
    logic [`PMW_PCNT_W-1:0] pcnt_reg [2], pref_reg [2];
    pmw_pkg::pmw_state_t state_reg, stateNext;

    always_comb begin
        mapped = 1'b1;
        rdNext = '0;
        if (paddr == `PMW_A_CTRL) begin
            rdNext[8:0] = ctrl_reg;
        end else if (paddr == `PMW_A_STAT) begin
            rdNext[2:0] = state_reg;
            rdNext[3]   = fromSleep_reg; // [RULE_21]
            rdNext[4]   = fromDeep_reg;
        end else if (paddr == `PMW_A_WEN) begin
            rdNext[`PMW_NSRC-1:0] = wen_reg;
        end else if (paddr == `PMW_A_WPEND) begin
            rdNext[`PMW_NSRC-1:0] = pend_reg; // [RULE_21]
        end else if (paddr == `PMW_A_DIOEDGE) begin
            rdNext[`PMW_NDIO-1:0] = dioEdge_reg;
        end else if (paddr == `PMW_A_CMPCFG) begin
            rdNext[3:0] = {cmpNow, cmpEdge_reg}; // [RULE_16]
        end else if (paddr == `PMW_A_TMR0LO) begin
            rdNext = tmrCnt_reg[0][31:0];
        end else if (paddr == `PMW_A_TMR0HI) begin
            rdNext[`PMW_TMR_HI_W-1:0] = tmrCnt_reg[0][`PMW_TMR_W-1:32];
        end else if (paddr == `PMW_A_TMR1LO) begin
            rdNext = tmrCnt_reg[1][31:0];
        end else if (paddr == `PMW_A_TMR1HI) begin
            rdNext[`PMW_TMR_HI_W-1:0] = tmrCnt_reg[1][`PMW_TMR_W-1:32];
        end else if (paddr == `PMW_A_PCNT0) begin
            rdNext = {pref_reg[0], pcnt_reg[0]};
        end else if (paddr == `PMW_A_PCNT1) begin
            rdNext = {pref_reg[1], pcnt_reg[1]};
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rstAll) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= apbAcc;
            prdata  <= (apbAcc & ~pwrite) ? rdNext : '0;
            pslverr <= apbAcc & ~mapped;
        end
    end

    logic wrCtrl;
    assign wrCtrl = wrDone & (paddr == `PMW_A_CTRL);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rstAll) begin
            ctrl_reg    <= `PMW_CTRL_RST;
            wen_reg     <= '0;
            dioEdge_reg <= '0;
            cmpEdge_reg <= '0;
        end else if (wrDone) begin
            if (paddr == `PMW_A_CTRL) begin
                // Request bits are strobes and are not stored
                ctrl_reg <= {pwdata[8:3], 3'h0};
            end else if (paddr == `PMW_A_WEN) begin
                wen_reg <= pwdata[`PMW_NSRC-1:0];
            end else if (paddr == `PMW_A_DIOEDGE) begin
                dioEdge_reg <= pwdata[`PMW_NDIO-1:0];
            end else if (paddr == `PMW_A_CMPCFG) begin
                cmpEdge_reg <= pwdata[1:0];
            end
        end
    end

    // ****************************************************************
    // Wake sources
    // ****************************************************************
    // Pin edges are seen at the pad, so alternate functions do not matter
    assign ev[`PMW_NDIO-1:0] = (dioEdge_reg & dioNow & ~dioOld) |
                               (~dioEdge_reg & ~dioNow & dioOld); // [RULE_15]
    assign ev[`PMW_W_CMP+1:`PMW_W_CMP] = (cmpEdge_reg & cmpNow & ~cmpOld) |
        (~cmpEdge_reg & ~cmpNow & cmpOld); // [RULE_16]

    logic timersRun;
    assign timersRun = wakeTimersOn;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gChan
            logic wrLo, wrHi, wrRef, deb, pulseIn, debSmp_reg, filt_reg;
            logic pulseOld_reg;
            assign wrLo  = wrDone & (paddr == `PMW_A_TMR0LO + 8'(8 * g));
            assign wrHi  = wrDone & (paddr == `PMW_A_TMR0HI + 8'(8 * g));
            assign wrRef = wrDone & (paddr == `PMW_A_PCNT0 + 8'(4 * g));
            // Down counter fires on reaching zero and then wraps on
            assign ev[`PMW_W_TMR+g] = tick & timersRun &
                (tmrCnt_reg[g] == `PMW_TMR_W'(1)); // [RULE_14]
            always_ff @(posedge clk) begin
                if (rstAll) begin
                    tmrCnt_reg[g] <= '0;
                end else if (wrLo) begin
                    tmrCnt_reg[g][31:0] <= pwdata;
                end else if (wrHi) begin
                    tmrCnt_reg[g][`PMW_TMR_W-1:32] <=
                        pwdata[`PMW_TMR_HI_W-1:0];
                end else if (ce & tick & timersRun) begin
                    tmrCnt_reg[g] <= tmrCnt_reg[g] - 1'b1; // [RULE_14]
                end
            end
            // Debounce needs the 32k tick; without it the raw pin counts
            assign deb     = ctrl_reg[`PMW_C_DEB+g];
            assign pulseIn = deb ? filt_reg : pulseNow[g]; // [RULE_19]
            assign ev[`PMW_W_PCNT+g] = pulseIn & ~pulseOld_reg &
                (pcnt_reg[g] + 1'b1 == pref_reg[g]); // [RULE_18]
            always_ff @(posedge clk) begin
                if (rstAll) begin
                    debSmp_reg   <= 1'b0;
                    filt_reg     <= 1'b0;
                    pulseOld_reg <= 1'b0;
                    pcnt_reg[g]  <= '0;
                    pref_reg[g]  <= '0;
                end else if (ce) begin
                    if (tick) begin
                        debSmp_reg <= pulseNow[g];
                        if (debSmp_reg == pulseNow[g]) begin
                            filt_reg <= debSmp_reg;
                        end
                    end
                    pulseOld_reg <= pulseIn;
                    // Counting never pauses for a wake or a write
                    if (pulseIn & ~pulseOld_reg) begin
                        pcnt_reg[g] <= pcnt_reg[g] + 1'b1; // [RULE_18]
                    end
                    if (wrRef) begin
                        pref_reg[g] <= pwdata[`PMW_PCNT_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk) begin
        if (rstAll) begin
            pend_reg <= '0;
        end else if (ce) begin
            pend_reg <= (pend_reg &
                ~((wrDone & (paddr == `PMW_A_WPEND)) ?
                  pwdata[`PMW_NSRC-1:0] : '0)) | ev; // [RULE_21]
        end
    end

    logic wakeAny, wakeDio;
    assign wakeAny = |(pend_reg & wen_reg); // [RULE_11]
    assign wakeDio = |(pend_reg[`PMW_NDIO-1:0] & wen_reg[`PMW_NDIO-1:0]);

    // ****************************************************************
    // Mode sequencer
    // ****************************************************************
    always_comb begin
        stateNext = state_reg;
        case (state_reg)
            pmw_pkg::ST_ACTIVE: begin
                if (wrCtrl & pwdata[`PMW_C_DEEP]) begin
                    stateNext = pmw_pkg::ST_DEEP;
                end else if (wrCtrl & pwdata[`PMW_C_SLEEP]) begin
                    stateNext = pmw_pkg::ST_SLEEP;
                end else if (wrCtrl & pwdata[`PMW_C_DOZE]) begin
                    stateNext = pmw_pkg::ST_DOZE; // [RULE_07]
                end
            end
            pmw_pkg::ST_DOZE: begin
                if (irqAny) begin
                    stateNext = pmw_pkg::ST_ACTIVE; // [RULE_07]
                end
            end
            pmw_pkg::ST_SLEEP: begin
                // A leftover enabled pending event wakes straight away
                if (wakeAny) begin
                    stateNext = pmw_pkg::ST_WAKE_BOD; // [RULE_12]
                end
            end
            pmw_pkg::ST_DEEP: begin
                if (wakeDio) begin
                    stateNext = pmw_pkg::ST_WAKE_BOD; // [RULE_20]
                end
            end
            pmw_pkg::ST_WAKE_BOD: begin
                if (bodOkS) begin
                    stateNext = pmw_pkg::ST_WAKE_OSC; // [RULE_13]
                end
            end
            pmw_pkg::ST_WAKE_OSC: begin
                if (oscStableS) begin
                    stateNext = pmw_pkg::ST_WAKE_PWR; // [RULE_13]
                end
            end
            pmw_pkg::ST_WAKE_PWR: stateNext = pmw_pkg::ST_WAKE_RST;
            pmw_pkg::ST_WAKE_RST: stateNext = pmw_pkg::ST_ACTIVE;
            default:              stateNext = pmw_pkg::ST_ACTIVE;
        endcase
        if (~ce) begin
            stateNext = state_reg;
        end
    end

    logic inSleep, inDeep, inRun, inWake, ramRet, oscOff, tmrOff, wakeDeep;
    // Origin must count in the first wake cycle, before the flag updates
    assign wakeDeep = (state_reg == pmw_pkg::ST_DEEP) |
                      (fromDeep_reg & (state_reg != pmw_pkg::ST_SLEEP));
    assign inSleep = (stateNext == pmw_pkg::ST_SLEEP);
    assign inDeep  = (stateNext == pmw_pkg::ST_DEEP);
    assign inRun   = (stateNext == pmw_pkg::ST_ACTIVE) |
                     (stateNext == pmw_pkg::ST_DOZE);
    assign inWake  = ~inRun & ~inSleep & ~inDeep;
    // Sleep options are taken from the same write that requests sleep
    assign ramRet  = wrCtrl ? pwdata[`PMW_C_RAMRET] : ctrl_reg[`PMW_C_RAMRET];
    assign oscOff  = wrCtrl ? pwdata[`PMW_C_OSCOFF] : ctrl_reg[`PMW_C_OSCOFF];
    assign tmrOff  = wrCtrl ? pwdata[`PMW_C_TMROFF] : ctrl_reg[`PMW_C_TMROFF];

    // Outputs follow the next state so they leave flops with it
    always_ff @(posedge clk) begin
        if (rstAll) begin
            state_reg    <= pmw_pkg::ST_ACTIVE;
            pwrDigital   <= 1'b1;
            pwrAnalog    <= 1'b1;
            pwrRam       <= 1'b1;
            pwrRadio     <= 1'b0;
            cpuHalt      <= 1'b0;
            cpuReset     <= 1'b0;
            chipReset    <= 1'b0;
            ioHold       <= 1'b0;
            dacHiZ       <= 1'b0;
            osc32Enable  <= 1'b1;
            osc32mEnable <= 1'b1;
            wakeTimersOn <= 1'b1;
        end else if (ce) begin
            state_reg    <= stateNext; // [RULE_01]
            pwrDigital   <= inRun | (stateNext == pmw_pkg::ST_WAKE_PWR) |
                            (stateNext == pmw_pkg::ST_WAKE_RST); // [RULE_03]
            pwrAnalog    <= inRun & ctrl_reg[`PMW_C_ANAON]; // [RULE_04]
            pwrRam       <= inRun | inWake | (inSleep & ramRet); // [RULE_05]
            pwrRadio     <= inRun & radioReq; // [RULE_06]
            cpuHalt      <= (stateNext == pmw_pkg::ST_DOZE); // [RULE_07]
            cpuReset     <= ~inRun; // [RULE_13]
            chipReset    <= inWake & wakeDeep; // [RULE_20]
            ioHold       <= ~inRun; // [RULE_08]
            dacHiZ       <= ~inRun; // [RULE_09]
            osc32Enable  <= ~inDeep & ~(inSleep & oscOff & ~wakeAny) &
                            ~(inWake & wakeDeep); // [RULE_10]
            osc32mEnable <= inRun | (inWake &
                            (stateNext != pmw_pkg::ST_WAKE_BOD)); // [RULE_13]
            wakeTimersOn <= ~inDeep & ~(inSleep & tmrOff); // [RULE_02]
        end
    end

    // Reset cause kept until the next wake from sleep or deep sleep
    always_ff @(posedge clk) begin
        if (rstAll) begin
            fromSleep_reg <= 1'b0;
            fromDeep_reg  <= 1'b0;
        end else if (ce) begin
            if (state_reg == pmw_pkg::ST_SLEEP && inWake) begin
                fromSleep_reg <= 1'b1; // [RULE_21]
                fromDeep_reg  <= 1'b0;
            end else if (state_reg == pmw_pkg::ST_DEEP && inWake) begin
                fromSleep_reg <= 1'b0;
                fromDeep_reg  <= 1'b1; // [RULE_20]
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rstAll);

    a_digital_off_sleep: assert property ( // [RULE_03]
        state_reg == pmw_pkg::ST_SLEEP |-> !pwrDigital && !cpuHalt)
        else $error("digital domain on in sleep");
    a_analog_off_sleep: assert property ( // [RULE_04]
        state_reg inside {pmw_pkg::ST_SLEEP, pmw_pkg::ST_DEEP} |-> !pwrAnalog)
        else $error("analogue domain on in sleep");
    a_ram_retain_sel: assert property ( // [RULE_05]
        $rose(state_reg == pmw_pkg::ST_SLEEP) |->
            pwrRam == $past(ramRet))
        else $error("ram retention differs from request");
    a_radio_off_sleep: assert property ( // [RULE_06]
        pwrRadio |-> $past(radioReq) && !ioHold)
        else $error("radio powered without request");
    a_doze_irq_exit: assert property ( // [RULE_07]
        state_reg == pmw_pkg::ST_DOZE && irqAny && ce |=>
            !cpuHalt && state_reg == pmw_pkg::ST_ACTIVE)
        else $error("doze not ended by interrupt");
    a_io_dac_hold: assert property ( // [RULE_08]
        state_reg == pmw_pkg::ST_SLEEP |-> ioHold && dacHiZ && cpuReset)
        else $error("pins not held in sleep");
    a_osc_restart: assert property ( // [RULE_10]
        state_reg == pmw_pkg::ST_SLEEP && wakeAny && ce |=>
            osc32Enable ##1 state_reg != pmw_pkg::ST_SLEEP)
        else $error("32k oscillator not restarted on wake");
    a_wake_needs_enable: assert property ( // [RULE_11]
        state_reg == pmw_pkg::ST_SLEEP && !wakeAny |=>
            state_reg == pmw_pkg::ST_SLEEP)
        else $error("woke without enabled source");
    a_wake_sequence: assert property ( // [RULE_13]
        state_reg == pmw_pkg::ST_WAKE_OSC && !oscStableS |=>
            !pwrDigital && cpuReset && osc32mEnable)
        else $error("power before oscillator stable");
    a_deep_all_off: assert property ( // [RULE_20]
        state_reg == pmw_pkg::ST_DEEP |-> !osc32Enable && !pwrRam &&
            !wakeTimersOn && !pwrDigital)
        else $error("domain on in deep sleep");

    c_doze_cycle: cover property (
        state_reg == pmw_pkg::ST_DOZE ##1 state_reg == pmw_pkg::ST_ACTIVE);
    c_sleep_wake: cover property (
        state_reg == pmw_pkg::ST_WAKE_RST && fromSleep_reg);
    c_deep_exit: cover property (chipReset ##1 !chipReset);
endmodule // pmw_power_wakeup_ctrl

// >>> test/pmw_wake_partner.sv
// Far side: wake pins, 32 kHz clock, supply and 32 MHz oscillator status
// Assumes the bench clock; pins follow the levels the bench asks for
`timescale 1ns/1ns
module pmw_wake_partner (
    // Clock, reset, bench pin request, controller oscillator enables
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] pinDrive,
    input  wire logic       osc32Enable,
    input  wire logic       osc32mEnable,
    // Levels seen by the controller
    output logic [7:0]      generalIoPin,
    output logic            osc32Clk,
    output logic            osc32mStable,
    output logic            bodOk
);
    logic [4:0] divCnt;
    logic [4:0] upCnt;
    assign generalIoPin = pinDrive;
    assign bodOk = 1'b1;
    // Slow start, so the wait for a stable oscillator is really seen
    always_ff @(posedge clk) begin
        divCnt <= (rst | ~osc32Enable) ? 5'h00 : divCnt + 5'h01;
        osc32Clk <= osc32Enable & divCnt[3]; // Stands still when off
        upCnt <= (rst | ~osc32mEnable) ? 5'h00 : upCnt + {4'h0, ~&upCnt};
        osc32mStable <= &upCnt;
    end
endmodule // pmw_wake_partner

// >>> test/tb_pmw_power_wakeup_ctrl.sv
// Bench: APB tasks set modes, partner pins wake the block
// Assumes one wait state per APB transfer and the partner model
`timescale 1ns/1ns
`include "pmw_consts.svh"
module tb_pmw_power_wakeup_ctrl;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        irqAny = 0, radioReq = 0, pready, pslverr, sl, saw;
    logic        pwrDigital, pwrAnalog, pwrRam, pwrRadio, cpuHalt, cpuReset;
    logic        chipReset, ioHold, dacHiZ, osc32Enable, osc32mEnable;
    logic        wakeTimersOn, osc32Clk, osc32mStable, bodOk;
    logic [7:0]  paddr = 0, pins = 0, gio;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0]  cmp = 0, pls = 0;
    logic        rstPinN = 1;
    int          error_cnt = 0, num_checks = 0, n;
    pmw_power_wakeup_ctrl u_dut (.clk(clk), .rst(rst), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .externalResetPinN(rstPinN), .generalIoPin(gio), .pulsePin(pls),
        .cmpLevel(cmp), .osc32Clk(osc32Clk), .bodOk(bodOk),
        .osc32mStable(osc32mStable), .irqAny(irqAny), .radioReq(radioReq),
        .pwrDigital(pwrDigital), .pwrAnalog(pwrAnalog), .pwrRam(pwrRam),
        .pwrRadio(pwrRadio), .cpuHalt(cpuHalt), .cpuReset(cpuReset),
        .chipReset(chipReset), .ioHold(ioHold), .dacHiZ(dacHiZ),
        .osc32Enable(osc32Enable), .osc32mEnable(osc32mEnable),
        .wakeTimersOn(wakeTimersOn));
    pmw_wake_partner u_far (.clk(clk), .rst(rst), .pinDrive(pins),
        .osc32Enable(osc32Enable), .osc32mEnable(osc32mEnable),
        .generalIoPin(gio), .osc32Clk(osc32Clk),
        .osc32mStable(osc32mStable), .bodOk(bodOk));
    initial forever #2 clk = ~clk;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %h", $time, m, got);
        end
    endtask
    // One idle edge first, so a release is never reassigned at once
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int k;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        sl = pslverr;
        psel <= 0;
        penable <= 0;
        if (k >= 20) chk(0, 1, "apb timeout");
        if (k >= 20) report_and_stop();
    endtask
    task automatic wake_wait;
        saw = 0;
        n = 0;
        // At least one edge, so the levels before a sleep request never count
        do begin
            @(posedge clk);
            saw |= chipReset;
            n++;
        end while (n < 300 && !(pwrDigital === 1 && cpuReset === 0));
        if (n >= 300) chk(0, 1, "wake timeout");
        if (n >= 300) report_and_stop();
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        apb(0, `PMW_A_CTRL, 0);
        chk(rd, 32'h40, "ctrl reset");
        chk({pwrDigital, pwrRam, pwrRadio, cpuHalt, ioHold}, 5'h18,
            "act");
        apb(0, 8'h18, 0);
        chk({sl, rd}, 33'h100000000, "unmapped");
        $display("test reset done");
        radioReq <= 1;
        apb(1, `PMW_A_CTRL, 32'h44);
        @(posedge clk);
        chk({cpuHalt, pwrDigital, pwrRadio}, 3'h7,
            "doze");
        irqAny <= 1;
        for (n = 0; n < 10 && cpuHalt !== 0; n++) @(posedge clk);
        chk(cpuHalt, 0, "doze end");
        irqAny <= 0;
        $display("test doze done");
        apb(1, `PMW_A_WEN, 1);
        apb(1, `PMW_A_DIOEDGE, 1);
        apb(1, `PMW_A_CTRL, 32'h59);
        @(posedge clk);
        chk({pwrDigital, pwrAnalog, pwrRam, pwrRadio, ioHold, dacHiZ,
            osc32Enable, wakeTimersOn}, 8'h2d,
            "sleep");
        pins <= 8'h02;
        repeat (20) @(posedge clk);
        chk(pwrDigital, 0, "masked pin");
        pins <= 8'h03;
        wake_wait();
        chk({saw, osc32Enable, pwrRadio}, 3'h3, "woken");
        apb(0, `PMW_A_STAT, 0);
        chk(rd[4:0], 5'h08, "stat");
        apb(0, `PMW_A_WPEND, 0);
        chk(rd[1:0], 2'h1, "pending");
        apb(1, `PMW_A_CTRL, 32'h41);
        wake_wait();
        chk(n > 4 && n < 60, 1, "rewake");
        $display("test sleep done");
        pins <= 8'h00;
        repeat (8) @(posedge clk);
        apb(1, `PMW_A_WPEND, 32'h3fff);
        apb(0, `PMW_A_WPEND, 0);
        chk(rd, 0, "cleared");
        apb(1, `PMW_A_PCNT0, 2);
        repeat (4) begin
            pls[0] <= ~pls[0];
            repeat (4) @(posedge clk);
        end
        apb(0, `PMW_A_PCNT0, 0);
        chk(rd, 32'h00020002, "pulse count");
        apb(0, `PMW_A_WPEND, 0);
        chk(rd, 32'h400, "pulse event");
        apb(1, `PMW_A_WEN, 32'h1001);
        apb(1, `PMW_A_CMPCFG, 1);
        apb(1, `PMW_A_CTRL, 32'h41);
        cmp <= 2'h1; // negative input comes from its pin
        wake_wait();
        apb(0, `PMW_A_CMPCFG, 0);
        chk({n > 4, rd[3:0]}, 5'h15, "cmp wake");
        apb(1, `PMW_A_WPEND, 32'h3fff);
        $display("test events done");
        apb(1, `PMW_A_CTRL, 32'h42);
        @(posedge clk);
        chk({pwrDigital, pwrAnalog, pwrRam, pwrRadio, osc32Enable}, 0,
            "deep");
        pins <= 8'h01;
        wake_wait();
        chk(saw, 1, "chip reset");
        apb(0, `PMW_A_STAT, 0);
        chk(rd[4:0], 5'h10, "deep stat");
        rstPinN <= 0;
        repeat (6) @(posedge clk);
        rstPinN <= 1;
        apb(0, `PMW_A_STAT, 0);
        chk(rd[4:0], 5'h00, "pin reset");
        $display("test deep done");
        report_and_stop();
    end
endmodule // tb_pmw_power_wakeup_ctrl
